// >>> include/csfm_pkg.sv
// Shared constants and types for the clock switch and fail monitor
package csfm_pkg;
   // Register byte offsets on the APB bus
   localparam logic [7:0] REQ_OFF = 8'h00;
   localparam logic [7:0] CUR_OFF = 8'h04;
   localparam logic [7:0] SWC_OFF = 8'h08;
   localparam logic [7:0] FLG_OFF = 8'h0c;
   localparam logic [7:0] IEN_OFF = 8'h10;
   // Field positions
   localparam int SRC_LSB = 4;
   localparam int HOLD_BIT = 7;
   localparam int SETTLED_BIT = 4;
   localparam int NEWRDY_BIT = 3;
   localparam int DONE_BIT = 0;
   localparam int FAIL_BIT = 1;
   // Source select codes
   localparam logic [2:0] SRC_EXT = 3'h7;
   localparam logic [2:0] SRC_HF = 3'h6;
   localparam logic [2:0] SRC_LF = 3'h5;
   localparam logic [2:0] SRC_EXT_PLL = 3'h2;
   localparam logic [2:0] SRC_HF_PLL = 3'h1;
   // Divider reset values and largest legal code
   localparam logic [3:0] DIV_RESET_HF = 4'h2;
   localparam logic [3:0] DIV_RESET_OTHER = 4'h0;
   localparam logic [3:0] DIV_MAX = 4'h9;
   // Timing counts
   localparam int STARTUP_COUNT = 1024;
   localparam int SAMPLE_DIV = 64;
   localparam int LOCK_WAIT_CYC = 1024;

   typedef enum logic [2:0] {
      ST_LOAD, ST_IDLE, ST_WAIT, ST_READY, ST_PLL, ST_SLEEP
   } csfm_state_t;

   function automatic logic csfm_is_pll(input logic [2:0] s);
      return s == SRC_EXT_PLL || s == SRC_HF_PLL;
   endfunction : csfm_is_pll

   function automatic logic csfm_is_ext(input logic [2:0] s);
      return s == SRC_EXT || s == SRC_EXT_PLL;
   endfunction : csfm_is_ext

   function automatic logic csfm_src_valid(input logic [2:0] s);
      return csfm_is_ext(s) || csfm_is_pll(s) || s == SRC_HF || s == SRC_LF;
   endfunction : csfm_src_valid
endpackage : csfm_pkg

// >>> rtl/csfm_fail_detect.sv
// External clock failure detector against a divided sample clock
`timescale 1ns/1ps
module csfm_fail_detect #(
   parameter int SAMPLE_DIV = csfm_pkg::SAMPLE_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_clk_pin,
   input wire logic lf_osc_pin,
   input wire logic armed,
   output logic ext_fall,
   output logic fail_pulse
);
   localparam int HALF = SAMPLE_DIV / 2;
   localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

   if (SAMPLE_DIV < 4 || SAMPLE_DIV % 2 != 0) begin : g_chk
      $error("SAMPLE_DIV must be even and at least 4");
   end

   logic [2:0] ext_sync_r;
   logic [2:0] lf_sync_r;
   logic ext_lvl_r;
   logic lf_lvl_r;
   logic [CW-1:0] lf_cnt_r;
   logic sample_r;
   logic latch_r;

   // Change counts only once second and third stage agree
   wire ext_agree = ext_sync_r[1] == ext_sync_r[2];
   wire lf_agree = lf_sync_r[1] == lf_sync_r[2];
   wire ext_fall_w = ext_agree & ~ext_sync_r[2] & ext_lvl_r;
   wire lf_rise_w = lf_agree & lf_sync_r[2] & ~lf_lvl_r;
   wire half_end = lf_rise_w && lf_cnt_r == CW'(HALF - 1);
   wire sample_rise = half_end & ~sample_r;
   wire sample_fall = half_end & sample_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync_r <= 3'h0;
         lf_sync_r <= 3'h0;
         ext_lvl_r <= 1'b0;
         lf_lvl_r <= 1'b0;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin};
         lf_sync_r <= {lf_sync_r[1:0], lf_osc_pin};
         if (ext_agree) ext_lvl_r <= ext_sync_r[2];
         if (lf_agree) lf_lvl_r <= lf_sync_r[2];
      end
   end

   // Sample clock is the slow oscillator divided by SAMPLE_DIV
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_cnt_r <= '0;
         sample_r <= 1'b0;
      end else if (lf_rise_w) begin
         lf_cnt_r <= half_end ? '0 : lf_cnt_r + CW'(1);
         if (half_end) sample_r <= ~sample_r;
      end
   end

   // Falling edge set beats a same-cycle sample clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= 1'b0;
         ext_fall <= 1'b0;
         fail_pulse <= 1'b0;
      end else begin
         if (ext_fall_w) latch_r <= 1'b1;
         else if (sample_rise) latch_r <= 1'b0;
         ext_fall <= ext_fall_w;
         fail_pulse <= armed & sample_fall & ~latch_r & ~ext_fall_w;
      end
   end

   a_fail_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
      fail_pulse |-> $past(armed))
      else $error("fail pulse without monitor armed");
   a_fall_keeps_ok: assert property (@(posedge pclk) disable iff (!presetn)
      ext_fall_w |=> ##1 !fail_pulse)
      else $error("failure declared right after an external edge");
endmodule : csfm_fail_detect

// >>> rtl/csfm_clock_switch.sv
// Clock source switch controller with fail-safe monitor and APB registers
`timescale 1ns/1ps
// How it works
// - Keep old clock until requested source ready
// - Ready sets new-ready bit and done flag
// - Hold clear: switch once new source ready
// - Hold set: stay on old clock
// - Switch in next cycle, no CPU gating
// - Status updates at switch; new-ready cleared
// - Request differs from status: start switch, outside fail-safe
// - PLL input change halts clock until lock
// - Sleep during pending switch: no switch
// - Wake, hold clear: new clock, done flag
// - Wake, hold set: old clock, request again
// - Monitor only when enabled, external sources
// - Sample clock divides slow oscillator by 64
// - Failure: internal 1 MHz, fail flag set
// - Fail-safe cleared by reset, sleep, request
// - External return restarts startup timer
// - Fail flag sets again if failure persists
// - Clock-input mode skips startup timer
// - Request: source bits 6-4, divider 3-0
// - Reserved source code write is ignored
// - Permit fuse low: request read-only
// - Reset divider 0010 for HF, else 0000
// - Source codes per fixed table
// - Divider codes 0 to 9: divide 1..512; request writes of codes above 9 are stored unchecked
// - Settled bit means request equals status
// - Startup timer counts 1024 oscillator cycles
module csfm_clock_switch #(
   parameter int STARTUP_COUNT = csfm_pkg::STARTUP_COUNT,
   parameter int LOCK_WAIT = csfm_pkg::LOCK_WAIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] reset_source_fuse,
   input wire logic switch_permit_fuse,
   input wire logic fail_monitor_enable,
   input wire logic external_clock_input_mode,
   input wire logic [3:0] osc_ready_pins,
   input wire logic ext_clk_pin,
   input wire logic lf_osc_pin,
   input wire logic sleep_enter,
   input wire logic wake_up,
   output logic [2:0] sys_source,
   output logic [3:0] sys_divider,
   output logic sys_fail_safe,
   output logic sys_halt,
   output logic [2:0] source_enable,
   output logic switch_irq,
   output logic clock_fail_irq
);
   localparam int OW = $clog2(STARTUP_COUNT + 1);
   localparam int LW = $clog2(LOCK_WAIT + 1);

   if (STARTUP_COUNT < 1 || LOCK_WAIT < 2) begin : g_chk
      $error("STARTUP_COUNT must be >= 1 and LOCK_WAIT >= 2");
   end

   csfm_pkg::csfm_state_t state_r;
   logic [6:0] req_r;
   logic [6:0] cur_r;
   logic hold_r;
   logic new_rdy_r;
   logic done_flag_r;
   logic fail_flag_r;
   logic sw_ien_r;
   logic fail_ien_r;
   logic fail_safe_r;
   logic permit_r;
   logic fcm_en_r;
   logic ec_mode_r;
   logic [2:0] rdy_s_r;
   logic [3:0] rdy1_r;
   logic [3:0] rdy2_r;
   logic [3:0] rdy3_r;
   logic [3:0] rdy_q_r;
   logic [OW-1:0] ost_cnt_r;
   logic [LW-1:0] lock_cnt_r;
   logic [31:0] rdata_nxt;
   logic hit_nxt;
   logic ext_fall;
   logic mon_fail;

   // Ready inputs: ext osc, HF, LF, PLL lock
   wire [2:0] req_src = req_r[6:4];
   wire [2:0] cur_src = cur_r[6:4];
   wire ost_done = ost_cnt_r == OW'(STARTUP_COUNT);
   wire ext_ok = rdy_q_r[0] & (ec_mode_r | ost_done);
   wire pll_in_chg = csfm_pkg::csfm_is_pll(req_src) &
      csfm_pkg::csfm_is_pll(cur_src) & (req_src != cur_src);
   wire base_rdy = csfm_pkg::csfm_is_ext(req_src) ? ext_ok :
      (req_src == csfm_pkg::SRC_LF) ? rdy_q_r[2] : rdy_q_r[1];
   // Outside fail-safe, a same source or divider-only change is ready at once
   wire new_rdy = ((req_src == cur_src) & ~fail_safe_r) |
      (base_rdy & (pll_in_chg | ~csfm_pkg::csfm_is_pll(req_src) |
      rdy_q_r[3]));
   wire settled = req_r == cur_r;

   // APB: setup cycle loads read data, access ends in one cycle
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready;
   wire wr_en = acc & pwrite;
   wire wr_req = wr_en & (paddr == csfm_pkg::REQ_OFF);
   wire wr_swc = wr_en & (paddr == csfm_pkg::SWC_OFF);
   wire wr_flg = wr_en & (paddr == csfm_pkg::FLG_OFF);
   wire wr_ien = wr_en & (paddr == csfm_pkg::IEN_OFF);
   wire [2:0] w_src = pwdata[6:4];
   wire req_ok = wr_req & permit_r & csfm_pkg::csfm_src_valid(w_src);
   wire req_int = req_ok & ~csfm_pkg::csfm_is_ext(w_src);

   // Events
   wire in_sleep = state_r == csfm_pkg::ST_SLEEP;
   wire [2:0] mon_src = fail_safe_r ? req_src : cur_src;
   wire armed = fcm_en_r & csfm_pkg::csfm_is_ext(mon_src) &
      (ec_mode_r | ost_done) & ~in_sleep;
   wire lock_fail = (state_r == csfm_pkg::ST_PLL) & ~rdy_q_r[3] &
      (lock_cnt_r == LW'(LOCK_WAIT - 1));
   wire fail_evt = mon_fail | lock_fail;
   // Sleep wins: no ready flags on the edge that enters sleep
   wire ready_evt = (state_r == csfm_pkg::ST_WAIT) & new_rdy & ~req_ok &
      ~sleep_enter;
   wire do_switch = (state_r == csfm_pkg::ST_READY) & ~hold_r & ~req_ok &
      ~pll_in_chg & ~sleep_enter;
   wire pll_done = (state_r == csfm_pkg::ST_PLL) & rdy_q_r[3] & ~sleep_enter;
   wire wake_go = in_sleep & wake_up & ~hold_r;
   wire done_set = ready_evt | wake_go;
   wire restart_ost = (req_ok && csfm_pkg::csfm_is_ext(w_src)) ||
      (state_r == csfm_pkg::ST_IDLE && csfm_pkg::csfm_is_ext(req_src) &&
      !settled) || (in_sleep && wake_up);

   always_comb begin
      rdata_nxt = 32'h0;
      hit_nxt = 1'b1;
      if (paddr == csfm_pkg::REQ_OFF) begin
         rdata_nxt[6:0] = req_r;
      end else if (paddr == csfm_pkg::CUR_OFF) begin
         rdata_nxt[6:0] = cur_r;
      end else if (paddr == csfm_pkg::SWC_OFF) begin
         rdata_nxt[csfm_pkg::HOLD_BIT] = hold_r;
         rdata_nxt[csfm_pkg::SETTLED_BIT] = settled;
         rdata_nxt[csfm_pkg::NEWRDY_BIT] = new_rdy_r;
      end else if (paddr == csfm_pkg::FLG_OFF) begin
         rdata_nxt[csfm_pkg::DONE_BIT] = done_flag_r;
         rdata_nxt[csfm_pkg::FAIL_BIT] = fail_flag_r;
      end else if (paddr == csfm_pkg::IEN_OFF) begin
         rdata_nxt[csfm_pkg::DONE_BIT] = sw_ien_r;
         rdata_nxt[csfm_pkg::FAIL_BIT] = fail_ien_r;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit_nxt;
         if (setup) prdata <= pwrite ? 32'h0 : rdata_nxt;
      end
   end

   // Oscillator ready pins: three stages, change once stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy1_r <= 4'h0;
         rdy2_r <= 4'h0;
         rdy3_r <= 4'h0;
         rdy_q_r <= 4'h0;
      end else begin
         rdy1_r <= osc_ready_pins;
         rdy2_r <= rdy1_r;
         rdy3_r <= rdy2_r;
         rdy_q_r <= (rdy2_r & rdy3_r) | (rdy_q_r & (rdy2_r | rdy3_r));
      end
   end

   // Startup timer counts synchronised external falling edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ost_cnt_r <= '0;
      end else if (restart_ost) begin
         ost_cnt_r <= '0;
      end else if (ext_fall && !ost_done) begin
         ost_cnt_r <= ost_cnt_r + OW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_r <= '0;
      end else if (state_r != csfm_pkg::ST_PLL) begin
         lock_cnt_r <= '0;
      end else if (!lock_fail) begin
         lock_cnt_r <= lock_cnt_r + LW'(1);
      end
   end

   // Sticky flags: hardware set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag_r <= 1'b0;
         fail_flag_r <= 1'b0;
         sw_ien_r <= 1'b0;
         fail_ien_r <= 1'b0;
      end else begin
         done_flag_r <= done_set |
            (done_flag_r & ~(wr_flg & pwdata[csfm_pkg::DONE_BIT]));
         fail_flag_r <= fail_evt |
            (fail_flag_r & ~(wr_flg & pwdata[csfm_pkg::FAIL_BIT]));
         if (wr_ien) begin
            sw_ien_r <= pwdata[csfm_pkg::DONE_BIT];
            fail_ien_r <= pwdata[csfm_pkg::FAIL_BIT];
         end
      end
   end

   // Fail-safe: internal return clears at write, external at switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_safe_r <= 1'b0;
      end else if (fail_evt) begin
         fail_safe_r <= 1'b1;
      end else if (sleep_enter || req_int) begin
         fail_safe_r <= 1'b0;
      end else if ((do_switch || pll_done) &&
         csfm_pkg::csfm_is_ext(req_src)) begin
         fail_safe_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r <= 1'b0;
      end else if (wr_swc) begin
         hold_r <= pwdata[csfm_pkg::HOLD_BIT];
      end
   end

   // Fuses are caught in the first cycle after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= csfm_pkg::ST_LOAD;
         req_r <= 7'h0;
         cur_r <= 7'h0;
         new_rdy_r <= 1'b0;
         permit_r <= 1'b0;
         fcm_en_r <= 1'b0;
         ec_mode_r <= 1'b0;
      end else begin
         if (req_ok) req_r <= pwdata[6:0];
         case (state_r)
            csfm_pkg::ST_LOAD: begin
               permit_r <= switch_permit_fuse;
               fcm_en_r <= fail_monitor_enable;
               ec_mode_r <= external_clock_input_mode;
               req_r[6:4] <= reset_source_fuse;
               cur_r[6:4] <= reset_source_fuse;
               req_r[3:0] <= (reset_source_fuse == csfm_pkg::SRC_HF) ?
                  csfm_pkg::DIV_RESET_HF : csfm_pkg::DIV_RESET_OTHER;
               cur_r[3:0] <= (reset_source_fuse == csfm_pkg::SRC_HF) ?
                  csfm_pkg::DIV_RESET_HF : csfm_pkg::DIV_RESET_OTHER;
               state_r <= csfm_pkg::ST_IDLE;
            end
            csfm_pkg::ST_IDLE: begin
               // After a failure only a fresh request restarts switching
               if (sleep_enter) state_r <= csfm_pkg::ST_SLEEP;
               else if ((!settled && !fail_safe_r) || req_ok)
                  state_r <= csfm_pkg::ST_WAIT;
            end
            csfm_pkg::ST_WAIT: begin
               if (sleep_enter) begin
                  state_r <= csfm_pkg::ST_SLEEP;
               end else if (ready_evt) begin
                  new_rdy_r <= 1'b1;
                  state_r <= csfm_pkg::ST_READY;
               end
            end
            csfm_pkg::ST_READY: begin
               if (sleep_enter) begin
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_SLEEP;
               end else if (req_ok) begin
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_IDLE;
               end else if (settled) begin
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_IDLE;
               end else if (!hold_r && pll_in_chg) begin
                  state_r <= csfm_pkg::ST_PLL;
               end else if (do_switch) begin
                  cur_r <= req_r;
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_IDLE;
               end
            end
            csfm_pkg::ST_PLL: begin
               if (sleep_enter) begin
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_SLEEP;
               end else if (pll_done) begin
                  cur_r <= req_r;
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_IDLE;
               end else if (lock_fail) begin
                  new_rdy_r <= 1'b0;
                  state_r <= csfm_pkg::ST_IDLE;
               end
            end
            csfm_pkg::ST_SLEEP: begin
               if (wake_up) begin
                  if (!hold_r) cur_r <= req_r;
                  state_r <= csfm_pkg::ST_IDLE;
               end
            end
            default: state_r <= csfm_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_source <= 3'h0;
         sys_divider <= 4'h0;
         sys_fail_safe <= 1'b0;
         sys_halt <= 1'b0;
         source_enable <= 3'h0;
         switch_irq <= 1'b0;
         clock_fail_irq <= 1'b0;
      end else begin
         sys_source <= fail_safe_r ? csfm_pkg::SRC_HF : cur_src;
         sys_divider <= fail_safe_r ? csfm_pkg::DIV_RESET_OTHER : cur_r[3:0];
         sys_fail_safe <= fail_safe_r;
         sys_halt <= state_r == csfm_pkg::ST_PLL;
         source_enable <= req_src;
         switch_irq <= done_flag_r & sw_ien_r;
         clock_fail_irq <= fail_flag_r & fail_ien_r;
      end
   end

   csfm_fail_detect #(
      .SAMPLE_DIV(csfm_pkg::SAMPLE_DIV)
   ) u_detect (
      .pclk(pclk),
      .presetn(presetn),
      .ext_clk_pin(ext_clk_pin),
      .lf_osc_pin(lf_osc_pin),
      .armed(armed),
      .ext_fall(ext_fall),
      .fail_pulse(mon_fail)
   );

   a_hold_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == csfm_pkg::ST_READY && hold_r) |=> $stable(cur_r))
      else $error("status changed while switch held");
   a_wait_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == csfm_pkg::ST_WAIT) |=> $stable(cur_r))
      else $error("status changed before source ready");
   a_ready_flags: assert property (@(posedge pclk) disable iff (!presetn)
      ready_evt |=> new_rdy_r && done_flag_r)
      else $error("ready did not set both bits");
   a_switch_done: assert property (@(posedge pclk) disable iff (!presetn)
      do_switch |=> (cur_r == $past(req_r)) && !new_rdy_r)
      else $error("switch did not update status");
   a_sleep_noswitch: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep && !wake_up |=> $stable(cur_r))
      else $error("switch taken during sleep");
   a_fail_forces_hf: assert property (@(posedge pclk) disable iff (!presetn)
      fail_evt |=> ##1 sys_fail_safe && sys_source == csfm_pkg::SRC_HF)
      else $error("failure did not force internal clock");
   a_bad_src_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_req && !csfm_pkg::csfm_src_valid(w_src)
      && state_r != csfm_pkg::ST_LOAD) |=> $stable(req_r))
      else $error("reserved source write changed request");
   a_fuse_locks: assert property (@(posedge pclk) disable iff (!presetn)
      (!permit_r && state_r != csfm_pkg::ST_LOAD) |=> $stable(req_r))
      else $error("request changed with switching not permitted");
   a_settled_bit: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == csfm_pkg::SWC_OFF) |=>
      prdata[csfm_pkg::SETTLED_BIT] == $past(settled))
      else $error("settled bit does not match registers");
endmodule : csfm_clock_switch

// >>> test/csfm_osc_model.sv
// Behavioural oscillator sources feeding the clock switch
`timescale 1ns/1ps
module csfm_osc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] source_enable,
   input wire logic ext_run,
   input wire logic [3:0] delay,
   output logic [3:0] osc_ready_pins,
   output logic ext_clk_pin,
   output logic lf_osc_pin
);
   logic [2:0] div_r;
   logic [4:0] age_r;
   logic [2:0] en_r;
   logic ext_r;
   logic late;
   // A dead crystal freezes its pin rather than idling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 3'h0;
         age_r <= 5'h00;
         en_r <= 3'h0;
         ext_r <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         en_r <= source_enable;
         if (en_r != source_enable) begin
            age_r <= 5'h00;
         end else if (age_r != 5'h1f) begin
            age_r <= age_r + 5'h01;
         end
         if (ext_run) begin
            ext_r <= div_r[2];
         end
      end
   end
   // Slow start only for the external and locked sources
   assign late = age_r < {1'b0, delay};
   assign ext_clk_pin = ext_r;
   assign lf_osc_pin = div_r[2];
   assign osc_ready_pins = {ext_run & !late, 2'b11, ext_run & !late};
endmodule : csfm_osc_model

// >>> test/tb_top.sv
// Register-level regression of the clock switch and fail monitor
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] RQ = csfm_pkg::REQ_OFF;
   localparam logic [7:0] CU = csfm_pkg::CUR_OFF;
   localparam logic [7:0] SW = csfm_pkg::SWC_OFF;
   localparam logic [7:0] FL = csfm_pkg::FLG_OFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] reset_source_fuse, sys_source, source_enable;
   logic switch_permit_fuse, sleep_enter, wake_up, ext_run;
   logic fail_monitor_enable;
   logic [3:0] osc_ready_pins, sys_divider, delay;
   logic ext_clk_pin, lf_osc_pin, sys_fail_safe, sys_halt;
   logic switch_irq, clock_fail_irq;
   int mismatches, comparisons;
   csfm_clock_switch #(.STARTUP_COUNT(4), .LOCK_WAIT(8)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .reset_source_fuse,
      .switch_permit_fuse, .fail_monitor_enable,
      .external_clock_input_mode(1'b0), .osc_ready_pins, .ext_clk_pin,
      .lf_osc_pin, .sleep_enter, .wake_up, .sys_source, .sys_divider,
      .sys_fail_safe, .sys_halt, .source_enable, .switch_irq,
      .clock_fail_irq);
   csfm_osc_model osc_u (.pclk, .presetn, .source_enable, .ext_run,
      .delay, .osc_ready_pins, .ext_clk_pin, .lf_osc_pin);
   task automatic results();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         mismatches++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rchk
   // Bounded register poll; running out ends the run
   task automatic poll(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while ((rd & m) !== v && n < 400);
      check(rd & m, v);
      if ((rd & m) !== v) begin
         results();
      end
   endtask : poll
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : do_reset
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      mismatches++;
      results();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sleep_enter, wake_up, delay} = '0;
      reset_source_fuse = csfm_pkg::SRC_HF;
      switch_permit_fuse = 1'b1;
      fail_monitor_enable = 1'b1;
      ext_run = 1'b1;
      mismatches = 0;
      comparisons = 0;
      do_reset();
      rchk(RQ, 32'h62);
      rchk(CU, 32'h62);
      rchk(SW, 32'h10);
      wr(csfm_pkg::IEN_OFF, 32'h3);
      wr(RQ, 32'he5);
      rchk(RQ, 32'h65);
      poll(SW, 32'h10, 32'h10);
      rchk(CU, 32'h65);
      rchk(FL, 32'h1);
      check(32'(switch_irq), 32'h1);
      check(32'(sys_divider), 32'h5);
      wr(FL, 32'h1);
      rchk(FL, 32'h0);
      wr(RQ, 32'h3a);
      rchk(RQ, 32'h65);
      apb(1'b0, 8'h14, 32'h0);
      check({rd[30:0], err}, 32'h1);
      // Hold: ready is flagged but the old clock keeps running
      wr(SW, 32'h80);
      wr(RQ, 32'h50);
      poll(SW, 32'h08, 32'h08);
      repeat (20) @(posedge pclk);
      rchk(CU, 32'h65);
      wr(SW, 32'h0);
      poll(CU, 32'hff, 32'h50);
      rchk(SW, 32'h10);
      delay <= 4'hf;
      wr(RQ, 32'h70);
      rchk(SW, 32'h0);
      rchk(CU, 32'h50);
      poll(CU, 32'hff, 32'h70);
      wr(FL, 32'h3);
      @(posedge pclk);
      ext_run <= 1'b0;
      poll(FL, 32'h2, 32'h2);
      check(32'(sys_fail_safe), 32'h1);
      check(32'(sys_source), 32'(csfm_pkg::SRC_HF));
      check(32'({sys_divider, 3'h0, clock_fail_irq}), 32'h1);
      wr(FL, 32'h2);
      poll(FL, 32'h2, 32'h2);
      wr(RQ, 32'h60);
      poll(SW, 32'h10, 32'h10);
      check(32'(sys_fail_safe), 32'h0);
      // Sleep with the external source still not ready
      wr(FL, 32'h3);
      wr(RQ, 32'h70);
      @(posedge pclk);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      repeat (10) @(posedge pclk);
      rchk(CU, 32'h60);
      ext_run <= 1'b1;
      wake_up <= 1'b1;
      @(posedge pclk);
      wake_up <= 1'b0;
      poll(CU, 32'hff, 32'h70);
      rchk(FL, 32'h1);
      // Wake with hold set keeps the old clock and asks again
      wr(SW, 32'h80);
      wr(RQ, 32'h60);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      wake_up <= 1'b1;
      @(posedge pclk);
      wake_up <= 1'b0;
      rchk(CU, 32'h70);
      poll(SW, 32'h08, 32'h08);
      wr(SW, 32'h0);
      poll(CU, 32'hff, 32'h60);
      reset_source_fuse <= csfm_pkg::SRC_EXT;
      switch_permit_fuse <= 1'b0;
      fail_monitor_enable <= 1'b0;
      do_reset();
      rchk(RQ, 32'h70);
      wr(RQ, 32'h62);
      rchk(RQ, 32'h70);
      // Monitor off: a dead external clock raises no flag
      ext_run <= 1'b0;
      repeat (800) @(posedge pclk);
      rchk(FL, 32'h0);
      results();
   end
endmodule : tb_top
